// [include/smc_pkg.sv]
package smc_pkg;
  // ----------------------------------------
  // Frame constants
  // ----------------------------------------
  localparam logic [7:0] CMD_HEADER = 8'haa;
  localparam logic [7:0] RSP_HEADER = 8'hbb;
  localparam logic [7:0] DEF_ADDR = 8'h01;
  localparam logic [7:0] OP_FACTORY = 8'h0f;
  localparam logic [7:0] SUB_MARKER = 8'h03;
  localparam logic [7:0] MARK_CLEAR = 8'h00;
  localparam logic [7:0] MARK_SET = 8'h01;
  localparam logic [7:0] STAT_OK_HI = 8'h00;
  localparam logic [7:0] STAT_NOTAG_LO = 8'h71;
  localparam logic [31:0] MARKER_SET_WORD = 32'h00000001;
  localparam logic [31:0] MARKER_CLEAR_WORD = 32'hffffffff;
  localparam logic [31:0] TAG_ID_ALL_ONES = 32'hffffffff;
  localparam logic [2:0] RSP_LAST = 3'h5;
  localparam logic [2:0] IDX_CRC_HI = 3'h4;

  typedef enum logic [2:0] {
    PS_HDR = 3'b000,
    PS_ADDR = 3'b001,
    PS_OP = 3'b010,
    PS_SUB = 3'b011,
    PS_VAL = 3'b100,
    PS_CRC_HI = 3'b101,
    PS_CRC_LO = 3'b110
  } smc_parse_e;
endpackage

// [include/smc_rsp_if.sv]
`timescale 1ns/1ps
interface smc_rsp_if;
  logic start;
  logic [7:0] addr;
  logic [7:0] statHi;
  logic [7:0] statLo;
  logic [15:0] crc;
  logic busy;
  modport ctl (output start, output addr, output statHi, output statLo, output crc, input busy);
  modport tx (input start, input addr, input statHi, input statLo, input crc, output busy);
endinterface

// [verif/smc_host_model.sv]
`timescale 1ns/1ps
module smc_host_model
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic flashWrite,
  input wire logic slow,
  output logic txReady,
  output logic flashDone
);
  logic [7:0] got[$];
  logic [1:0] dly;
  always @(posedge mclk) begin
    if (!nrst) begin
      txReady <= 1'b0;
      flashDone <= 1'b0;
      dly <= 2'h0;
    end else begin
      txReady <= slow ? !txReady : 1'b1;
      if (txValid && txReady) got.push_back(txData);
      flashDone <= dly == 2'h1;
      dly <= flashWrite ? 2'h3 : dly - (dly != 2'h0);
    end
  end
endmodule

// [verif/smc_marker_cmd_sva.sv]
`timescale 1ns/1ps
module smc_marker_cmd_sva
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic flashWrite,
  input wire logic [31:0] flashWData,
  input wire logic tagIdWrite,
  input wire logic tagScanned,
  input wire logic tagSearch,
  input wire logic normalOp,
  input wire logic errNoTag,
  input wire logic errReportTick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_set_tag_id: assert property (flashWrite && flashWData == MARKER_SET_WORD |-> tagIdWrite)
    else $error("set without tag id write");
  a_clear_wait: assert property (flashWrite && flashWData == MARKER_CLEAR_WORD |-> ##[0:1] errNoTag)
    else $error("clear without waiting");
  a_rsp_header: assert property ($rose(txValid) |-> txData == RSP_HEADER)
    else $error("response not opened by header");
  a_tick_start: assert property (errReportTick |-> ##[1:2] txValid && txData == RSP_HEADER)
    else $error("error tick without response");
  a_wait_state: assert property (errNoTag |-> tagSearch && !normalOp)
    else $error("waiting state inconsistent");
  a_scan_resume: assert property (errNoTag && tagScanned |-> ##[1:2] normalOp && !errNoTag)
    else $error("scan did not resume");
  a_set_resume: assert property (tagIdWrite |-> ##[0:2] normalOp && !tagSearch)
    else $error("set did not resume");
  a_normal_quiet: assert property (normalOp |-> !errReportTick)
    else $error("error report in normal state");
  cover property (errReportTick);
  cover property (tagIdWrite);
  cover property (errNoTag && tagScanned);
endmodule

bind smc_marker_cmd smc_marker_cmd_sva chk (.*);

// [verif/tb_smc_marker_cmd.sv]
`timescale 1ns/1ps
module tb_smc_marker_cmd
  import smc_pkg::*;
();
  logic mclk, txValid, txReady, flashWrite, flashDone, tagIdWrite;
  logic nrst = 1'b0, rxValid = 1'b0, rxFrameEnd = 1'b0, slow = 1'b0;
  logic flashMarkerValid = 1'b1, tagScanned = 1'b0, tagSearch, normalOp, errNoTag, errReportTick;
  logic [7:0] rxData = 8'h00, txData, ownAddr = DEF_ADDR;
  logic [15:0] rspCrc = 16'h3288;
  logic [31:0] flashMarker = MARKER_SET_WORD, flashWData, tagIdData, lastW, lastT;
  int error_cnt = 0, n_compared = 0, cyc = 0, wrCnt = 0, tickCnt = 0, n;
  smc_marker_cmd dut (.*);
  smc_host_model host (.*);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (flashWrite === 1'b1) wrCnt++;
    if (errReportTick === 1'b1) tickCnt++;
    if (flashWrite === 1'b1) lastW <= flashWData;
    if (tagIdWrite === 1'b1) lastT <= tagIdData;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  task automatic check(input string s, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wt(input int c);
    repeat (c) @(posedge mclk);
  endtask
  // Corrupts byte number bad, none when bad is 7
  task automatic frame(input logic [7:0] v, input int crc, bad);
    logic [7:0] b[7];
    b = '{CMD_HEADER, DEF_ADDR, OP_FACTORY, SUB_MARKER, v, 8'h72, 8'h10};
    for (int i = 0; i < 5 + 2 * crc; i++) begin
      @(posedge mclk);
      rxData <= b[i] ^ (i == bad ? 8'h40 : 8'h00);
      rxValid <= 1'b1;
    end
    @(posedge mclk);
    rxValid <= 1'b0;
    rxFrameEnd <= 1'b1;
    @(posedge mclk);
    rxFrameEnd <= 1'b0;
  endtask
  task automatic quiet();
    int c;
    wt(40);
    c = host.got.size();
    wt(60);
    check("quiet", host.got.size(), c);
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    wt(2);
    nrst <= 1'b1;
    wt(4);
    check("normal", normalOp, 1'b1);
    for (int k = 0; k < 5; k++) frame(MARK_CLEAR, 1, k);
    wt(10);
    check("writes", wrCnt, 0);
    slow <= 1'b1;
    frame(MARK_CLEAR, 1, 7);
    wt(3);
    check("clear", lastW, MARKER_CLEAR_WORD);
    for (n = 0; n < 500 && host.got.size() < 12; n++) @(posedge mclk);
    check("hdr", {host.got[0], host.got[1]}, {RSP_HEADER, DEF_ADDR});
    check("stat", {host.got[2], host.got[3]}, {STAT_OK_HI, STAT_NOTAG_LO});
    check("crc", {host.got[4], host.got[5]}, rspCrc);
    check("again", host.got[6], RSP_HEADER);
    check("ticks", tickCnt, 2);
    check("wait", {errNoTag, tagSearch, normalOp}, 3'b110);
    tagScanned <= 1'b1;
    @(posedge mclk) tagScanned <= 1'b0;
    quiet();
    check("scan", {errNoTag, normalOp}, 2'b01);
    frame(MARK_CLEAR, 0, 7);
    wt(20);
    frame(MARK_SET, 0, 7);
    wt(3);
    check("set", lastW, MARKER_SET_WORD);
    check("tagid", lastT, TAG_ID_ALL_ONES);
    quiet();
    check("norm", {errNoTag, tagSearch, normalOp}, 3'b001);
    nrst <= 1'b0;
    flashMarker <= MARKER_CLEAR_WORD;
    wt(2);
    nrst <= 1'b1;
    wt(4);
    check("boot", {errNoTag, normalOp}, 2'b10);
    final_report();
  end
endmodule

// [verilog/smc_marker_cmd.sv]
`timescale 1ns/1ps
// Operation
// - Command frames begin with header 0xaa
// - Act only on frames to own address
// - Opcode 0x0f selects factory category
// - Sub-opcode 0x03 then marker value byte
// - Value 0x00 clears marker, waits for setup tag
// - Value 0x01 writes word 0x00000001
// - Optional CRC pair ends frames
// - Response: 0xbb, address, status, CRC
// - Clear without tag answers 0x00 0x71
// - Waiting: search tag, block, report error
// - Scanned setup tag resumes normal operation
// - No response to set command
// - Set command makes tag id all ones
// - Marker set: no tag requests, normal
// - Only marker changes, no full reformat
// - Clear writes all-ones marker word
module smc_marker_cmd
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] ownAddr,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic rxFrameEnd,
  input wire logic [15:0] rspCrc,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  input wire logic [31:0] flashMarker,
  input wire logic flashMarkerValid,
  output logic flashWrite,
  output logic [31:0] flashWData,
  input wire logic flashDone,
  output logic tagIdWrite,
  output logic [31:0] tagIdData,
  input wire logic tagScanned,
  output logic tagSearch,
  output logic normalOp,
  output logic errNoTag,
  output logic errReportTick
);
  typedef struct packed {
    smc_parse_e ps;
    logic hit;
    logic [7:0] value;
    logic waiting;
    logic loaded;
    logic flashWrite;
    logic [31:0] flashWData;
    logic flashBusy;
    logic tagIdWrite;
    logic rspPend;
    logic rspStart;
    logic errTick;
  } smc_main_s;

  smc_main_s st_r;
  smc_main_s st_nxt;
  smc_rsp_if rspBus ();

  // ----------------------------------------
  // Frame parser and marker control
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.flashWrite = 1'b0;
    st_nxt.tagIdWrite = 1'b0;
    st_nxt.rspStart = 1'b0;
    st_nxt.errTick = 1'b0;
    if (!st_r.loaded && flashMarkerValid) begin
      st_nxt.loaded = 1'b1;
      st_nxt.waiting = (flashMarker != MARKER_SET_WORD);
    end
    if (flashDone) begin
      st_nxt.flashBusy = 1'b0;
    end
    if (rxValid) begin
      unique case (st_r.ps)
        PS_HDR: begin
          if (rxData == CMD_HEADER) begin
            st_nxt.ps = PS_ADDR;
          end
        end
        PS_ADDR: begin
          st_nxt.hit = (rxData == ownAddr);
          st_nxt.ps = PS_OP;
        end
        PS_OP: begin
          st_nxt.hit = st_r.hit && (rxData == OP_FACTORY);
          st_nxt.ps = PS_SUB;
        end
        PS_SUB: begin
          st_nxt.hit = st_r.hit && (rxData == SUB_MARKER);
          st_nxt.ps = PS_VAL;
        end
        PS_VAL: begin
          st_nxt.value = rxData;
          st_nxt.ps = PS_CRC_HI;
          // Only marker state changes; no reformat of anything else
          if (st_r.hit && rxData == MARK_CLEAR) begin
            st_nxt.waiting = 1'b1;
            st_nxt.flashWrite = 1'b1;
            st_nxt.flashWData = MARKER_CLEAR_WORD;
            st_nxt.flashBusy = 1'b1;
            st_nxt.rspPend = 1'b1;
          end else if (st_r.hit && rxData == MARK_SET) begin
            st_nxt.waiting = 1'b0;
            st_nxt.flashWrite = 1'b1;
            st_nxt.flashWData = MARKER_SET_WORD;
            st_nxt.flashBusy = 1'b1;
            st_nxt.tagIdWrite = 1'b1;
            st_nxt.rspPend = 1'b0;
          end
        end
        PS_CRC_HI: begin
          st_nxt.ps = PS_CRC_LO;
        end
        PS_CRC_LO: begin
          st_nxt.ps = PS_HDR;
        end
        default: begin
          st_nxt.ps = PS_HDR;
        end
      endcase
    end
    // CRC bytes are optional, so frame end also resynchronises
    if (rxFrameEnd) begin
      st_nxt.ps = PS_HDR;
      st_nxt.hit = 1'b0;
    end
    if (st_r.waiting && tagScanned) begin
      st_nxt.waiting = 1'b0;
      st_nxt.rspPend = 1'b0;
    end
    // A scan or set command in this cycle cancels a response not yet started
    if (st_r.rspPend && st_nxt.waiting && !rspBus.busy && !st_r.flashBusy
        && !st_r.rspStart) begin
      st_nxt.rspPend = 1'b0;
      st_nxt.rspStart = 1'b1;
      st_nxt.errTick = 1'b1;
    end
    if (st_r.waiting && !st_r.rspPend && !rspBus.busy && !st_r.rspStart
        && !st_nxt.rspStart && !tagScanned) begin
      st_nxt.rspPend = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rspBus.start = st_r.rspStart;
  assign rspBus.addr = ownAddr;
  assign rspBus.statHi = STAT_OK_HI;
  assign rspBus.statLo = STAT_NOTAG_LO;
  assign rspBus.crc = rspCrc;

  smc_rsp_tx uTx (
    .mclk(mclk),
    .nrst(nrst),
    .rsp(rspBus),
    .txData(txData),
    .txValid(txValid),
    .txReady(txReady)
  );

  assign flashWrite = st_r.flashWrite;
  assign flashWData = st_r.flashWData;
  assign tagIdWrite = st_r.tagIdWrite;
  assign tagIdData = TAG_ID_ALL_ONES;
  assign tagSearch = st_r.waiting;
  assign normalOp = st_r.loaded && !st_r.waiting;
  assign errNoTag = st_r.waiting;
  assign errReportTick = st_r.errTick;
endmodule

// [verilog/smc_rsp_tx.sv]
`timescale 1ns/1ps
module smc_rsp_tx
  import smc_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  smc_rsp_if.tx rsp,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady
);
  typedef struct packed {
    logic busy;
    logic [2:0] idx;
    logic [47:0] frame;
  } smc_tx_s;

  smc_tx_s st_r;
  smc_tx_s st_nxt;

  // ----------------------------------------
  // Response serialiser
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (!st_r.busy && rsp.start) begin
      st_nxt.busy = 1'b1;
      st_nxt.idx = 3'h0;
      st_nxt.frame = {RSP_HEADER, rsp.addr, rsp.statHi, rsp.statLo, rsp.crc};
    end else if (st_r.busy && txReady) begin
      st_nxt.frame = {st_r.frame[39:0], 8'h00};
      st_nxt.idx = st_r.idx + 3'h1;
      if (st_r.idx == RSP_LAST) begin
        st_nxt.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign txData = st_r.frame[47:40];
  assign txValid = st_r.busy;
  assign rsp.busy = st_r.busy;
endmodule
